// ==== verilog/sqc_pkg.sv ====
/*
 Constants for the transceiver quad configuration register space.
 Assumes 8 quads of 4 channels, an 18-bit byte address and byte data.
*/
package sqc_pkg;
	localparam int NUM_QUADS   = 8;
	localparam int CH_PER_QUAD = 4;
	localparam int NUM_CH      = NUM_QUADS * CH_PER_QUAD;
	localparam int ADDR_W      = 18;
	localparam int DATA_W      = 8;
	localparam int SYNC_STAGES = 3;

	// Printed base addresses of the register map
	localparam logic [17:0] BASE_CH_BCAST_L  = 18'h3_0000;
	localparam logic [17:0] BASE_CH_SIDE_L   = 18'h3_4000;
	localparam logic [17:0] BASE_CH_SINGLE_L = 18'h3_5000;
	localparam logic [17:0] BASE_QUAD_L      = 18'h3_6000;
	localparam logic [17:0] BASE_QUAD_BC_L   = 18'h3_6400;
	localparam logic [17:0] BASE_CH_BCAST_R  = 18'h3_8000;
	localparam logic [17:0] BASE_CH_SIDE_R   = 18'h3_C000;
	localparam logic [17:0] BASE_CH_SINGLE_R = 18'h3_D000;
	localparam logic [17:0] BASE_QUAD_R      = 18'h3_E000;
	localparam logic [17:0] BASE_QUAD_BC_R   = 18'h3_E400;
	localparam logic [17:0] BASE_IIR         = 18'h3_EF00;

	// Address fields derived from the bases above
	localparam logic [1:0] ADDR_TOP        = BASE_IIR[17:16];
	localparam int         SIDE_BIT        = 15;
	localparam logic [2:0] REGION_CH_SIDE  = BASE_CH_SIDE_L[14:12];
	localparam logic [2:0] REGION_CH_ONE   = BASE_CH_SINGLE_L[14:12];
	localparam logic [2:0] REGION_QUAD     = BASE_QUAD_L[14:12];
	localparam logic [3:0] QSEL_BCAST      = BASE_QUAD_BC_L[11:8];
	localparam logic [3:0] QSEL_IIR        = BASE_IIR[11:8];

	// Register offsets
	localparam logic [7:0] OFS_LINK_SYNC   = 8'h00;
	localparam logic [7:0] OFS_CH_PWR      = 8'h13;
	localparam logic [7:0] OFS_PROTO       = 8'h18;
	localparam logic [7:0] OFS_QUAD_PWR    = 8'h28;
	localparam logic [7:0] OFS_XCVR_RST    = 8'h41;
	localparam logic [7:0] OFS_QUAD_SRST   = 8'h43;
	localparam logic [7:0] OFS_IIR_SCRATCH = 8'h00;

	// Field positions: printed bit n sits at data[7-n]
	localparam int POS_LINK_SYNC = DATA_W - 1 - 7;
	localparam int POS_RX_PWR    = DATA_W - 1 - 6;
	localparam int POS_TX_PWR    = DATA_W - 1 - 7;
	localparam int POS_QUAD_PWR  = DATA_W - 1 - 1;
	localparam int POS_XCVR_RST  = DATA_W - 1 - 5;
	localparam int POS_QUAD_SRST = DATA_W - 1 - 7;

	// Hardware defaults
	localparam logic [7:0] RST_LINK_SYNC = 8'h00;
	localparam logic [7:0] RST_CH_PWR    = 8'h00;
	localparam logic [7:0] RST_PROTO     = 8'h00;
	localparam logic [7:0] RST_QUAD_PWR  = 8'h00;
	localparam logic [7:0] RST_XCVR_RST  = 8'h04;
	localparam logic [7:0] RST_QUAD_SRST = 8'h00;
	localparam logic [7:0] RST_IIR       = 8'h00;
	localparam logic [7:0] RST_RDATA     = 8'h00;

	localparam logic [7:0] PROTO_XAUI    = 8'h01;
endpackage

// ==== verilog/sqc_regs.sv ====
/*
 Configuration register space of an 8-quad, 32-channel transceiver block,
 with single, quad-wide and side-wide broadcast writes and a loader port.
 Assumes the system bus and the configuration loader share clock_i, and
 that the quad reset pins arrive asynchronously.
*/
// How it works
// - Every shared, quad and channel register has its own 18-bit address.
// - Full address is the register offset added to the quad/channel base.
// - A single-channel write changes only that channel's copy.
// - A four-channel base per quad writes the register in all its channels.
// - Side-wide channel bases write the register in every quad on that side.
// - Side-wide quad bases write the quad register in every quad of that side.
// - The shared inter-quad group sits at its own base address.
// - Registers are bytes; printed bit 0 is the MSB, bit 7 the LSB.
// - Quad reset by register bit or pin restores hardware defaults.
// - The configuration loader writes quad and channel registers without bus.
// - Value 0x01 in quad offset 0x18 selects the 10G attachment-unit mode.
// - That mode aligns transmit clocks, sets transmit machine, enables encoder.
// - That mode enables aligner and decoder, sets receive link and rx machines.
// - Quad offset 0x28 bit 1 powers the quad up.
// - Channel offset 0x13 bit 6 powers receive, bit 7 powers transmit.
// - Quads and channels stay powered down from reset until bits are written.
// - Channel offset 0x00 bit 7 enables the receive link machine, default off.
// - Transceiver reset defaults on; clearing quad 0x41 bit 5 releases it.
// - Any change of the link enable forces that link machine to no-sync.
`timescale 1ns/1ps

module sqc_regs
	import sqc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	// System bus
	input  wire logic [ADDR_W-1:0]    sb_addr_i,
	input  wire logic [DATA_W-1:0]    sb_wdata_i,
	input  wire logic                 sb_we_i,
	input  wire logic                 sb_re_i,
	output logic      [DATA_W-1:0]    sb_rdata_o,
	output logic                      sb_ack_o,
	// Configuration loader
	input  wire logic                 cfg_we_i,
	input  wire logic [ADDR_W-1:0]    cfg_addr_i,
	input  wire logic [DATA_W-1:0]    cfg_data_i,
	// Quad reset pins
	input  wire logic [NUM_QUADS-1:0] quad_rst_i,
	// Per-quad controls
	output logic      [NUM_QUADS-1:0] quad_pwr_up_o,
	output logic      [NUM_QUADS-1:0] xcvr_rst_o,
	output logic      [NUM_QUADS-1:0] xaui_mode_o,
	output logic      [NUM_QUADS-1:0] tx_clk_sync_o,
	output logic      [NUM_QUADS-1:0] tx_sm_xaui_o,
	output logic      [NUM_QUADS-1:0] enc_en_o,
	output logic      [NUM_QUADS-1:0] word_align_en_o,
	output logic      [NUM_QUADS-1:0] dec_en_o,
	output logic      [NUM_QUADS-1:0] rx_link_sm_xaui_o,
	output logic      [NUM_QUADS-1:0] rx_sm_xaui_o,
	// Per-channel controls
	output logic      [NUM_CH-1:0]    rx_pwr_up_o,
	output logic      [NUM_CH-1:0]    tx_pwr_up_o,
	output logic      [NUM_CH-1:0]    link_sync_enable_o,
	output logic      [NUM_CH-1:0]    link_nosync_o
);

	logic [DATA_W-1:0] link_sync_q [NUM_CH];
	logic [DATA_W-1:0] ch_pwr_q    [NUM_CH];
	logic [DATA_W-1:0] proto_q     [NUM_QUADS];
	logic [DATA_W-1:0] quad_pwr_q  [NUM_QUADS];
	logic [DATA_W-1:0] xcvr_rst_q  [NUM_QUADS];
	logic [DATA_W-1:0] quad_srst_q [NUM_QUADS];
	logic [DATA_W-1:0] iir_q;
	logic [NUM_CH-1:0] link_prev_q;

	logic [SYNC_STAGES-1:0] qrst_sync_q [NUM_QUADS];
	logic [NUM_QUADS-1:0]   qrst_pin_q;
	logic [NUM_QUADS-1:0]   quad_clr;

	// Write path: the loader takes precedence over the bus
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_space;
	logic              wr_side;
	logic [2:0]        wr_region;
	logic [3:0]        wr_qsel;
	logic [1:0]        wr_cq;
	logic [1:0]        wr_cc;
	logic [7:0]        wr_ofs;
	logic [NUM_QUADS-1:0] quad_hit;
	logic [NUM_CH-1:0]    ch_hit;
	logic              iir_hit;

	// A bus write that meets a loader write is lost, yet still acked
	assign wr_en     = sb_we_i | cfg_we_i;
	assign wr_addr   = cfg_we_i ? cfg_addr_i : sb_addr_i;
	assign wr_data   = cfg_we_i ? cfg_data_i : sb_wdata_i;
	assign wr_space  = wr_addr[17:16] == ADDR_TOP;
	assign wr_side   = wr_addr[SIDE_BIT];
	assign wr_region = wr_addr[14:12];
	assign wr_qsel   = wr_addr[11:8];
	assign wr_cq     = wr_addr[11:10];
	assign wr_cc     = wr_addr[9:8];
	assign wr_ofs    = wr_addr[7:0];

	// The shared group is one scratch byte, reached on the right side only
	assign iir_hit = wr_en && wr_space && wr_side
		&& wr_region == REGION_QUAD && wr_qsel == QSEL_IIR;

	// Quad q sits on side q/4 at slot q%4; broadcast hits every slot
	genvar q;
	generate
		for (q = 0; q < NUM_QUADS; q++)
		begin : g_quad
			localparam logic       QSIDE = (q / CH_PER_QUAD) != 0;
			localparam logic [1:0] QSLOT = 2'(q % CH_PER_QUAD);

			assign quad_hit[q] = wr_en && wr_space && wr_side == QSIDE
				&& wr_region == REGION_QUAD
				&& (wr_qsel == {2'b00, QSLOT}
				|| wr_qsel == QSEL_BCAST);

			// Pin reset passes three flops; only an agreed change counts
			// The first flop feeds only the second, so a metastable value
			// never reaches the decision
			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					qrst_sync_q[q] <= '0;
					qrst_pin_q[q]  <= 1'b0;
				end
				else
				begin
					qrst_sync_q[q] <= {qrst_sync_q[q][SYNC_STAGES-2:0],
						quad_rst_i[q]};
					if (qrst_sync_q[q][1] == qrst_sync_q[q][2])
						qrst_pin_q[q] <= qrst_sync_q[q][2];
				end
			end

			assign quad_clr[q] = qrst_pin_q[q]
				| quad_srst_q[q][POS_QUAD_SRST];

			// Soft reset bit itself only clears on the pin, so it can be
			// held and released by software
			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
					quad_srst_q[q] <= RST_QUAD_SRST;
				else if (qrst_pin_q[q])
					quad_srst_q[q] <= RST_QUAD_SRST;
				else if (quad_hit[q] && wr_ofs == OFS_QUAD_SRST)
					quad_srst_q[q] <= wr_data;
			end

			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					proto_q[q]    <= RST_PROTO;
					quad_pwr_q[q] <= RST_QUAD_PWR;
					xcvr_rst_q[q] <= RST_XCVR_RST;
				end
				else if (quad_clr[q])
				begin
					proto_q[q]    <= RST_PROTO;
					quad_pwr_q[q] <= RST_QUAD_PWR;
					xcvr_rst_q[q] <= RST_XCVR_RST;
				end
				else if (quad_hit[q])
				begin
					if (wr_ofs == OFS_PROTO)
						proto_q[q] <= wr_data;
					if (wr_ofs == OFS_QUAD_PWR)
						quad_pwr_q[q] <= wr_data;
					if (wr_ofs == OFS_XCVR_RST)
						xcvr_rst_q[q] <= wr_data;
				end
			end

			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					xaui_mode_o[q]   <= 1'b0;
					quad_pwr_up_o[q] <= 1'b0;
					xcvr_rst_o[q]    <= 1'b1;
				end
				else
				begin
					xaui_mode_o[q]   <= proto_q[q] == PROTO_XAUI;
					quad_pwr_up_o[q] <= quad_pwr_q[q][POS_QUAD_PWR];
					xcvr_rst_o[q]    <= xcvr_rst_q[q][POS_XCVR_RST];
				end
			end

			// The mode drives the whole datapath setup with one write
			// Outputs lag their registers by one flop, so a loader image
			// and a bus write look the same downstream
			assign tx_clk_sync_o[q]     = xaui_mode_o[q];
			assign tx_sm_xaui_o[q]      = xaui_mode_o[q];
			assign enc_en_o[q]          = xaui_mode_o[q];
			assign word_align_en_o[q]   = xaui_mode_o[q];
			assign dec_en_o[q]          = xaui_mode_o[q];
			assign rx_link_sm_xaui_o[q] = xaui_mode_o[q];
			assign rx_sm_xaui_o[q]      = xaui_mode_o[q];
		end
	endgenerate

	// Channel c sits in quad c/4 and follows that quad's reset
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++)
		begin : g_ch
			localparam int         CQ    = c / CH_PER_QUAD;
			localparam logic       CSIDE = (CQ / CH_PER_QUAD) != 0;
			localparam logic [1:0] CSLOT = 2'(CQ % CH_PER_QUAD);
			localparam logic [1:0] CIDX  = 2'(c % CH_PER_QUAD);

			assign ch_hit[c] = wr_en && wr_space && wr_side == CSIDE
				&& ((wr_region == {1'b0, CSLOT})
				|| wr_region == REGION_CH_SIDE
				|| (wr_region == REGION_CH_ONE
				&& wr_cq == CSLOT && wr_cc == CIDX));

			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					link_sync_q[c] <= RST_LINK_SYNC;
					ch_pwr_q[c]    <= RST_CH_PWR;
				end
				else if (quad_clr[CQ])
				begin
					link_sync_q[c] <= RST_LINK_SYNC;
					ch_pwr_q[c]    <= RST_CH_PWR;
				end
				else if (ch_hit[c])
				begin
					if (wr_ofs == OFS_LINK_SYNC)
						link_sync_q[c] <= wr_data;
					if (wr_ofs == OFS_CH_PWR)
						ch_pwr_q[c] <= wr_data;
				end
			end

			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					link_sync_enable_o[c] <= 1'b0;
					rx_pwr_up_o[c]        <= 1'b0;
					tx_pwr_up_o[c]        <= 1'b0;
					link_prev_q[c]        <= 1'b0;
					link_nosync_o[c]      <= 1'b0;
				end
				else
				begin
					link_sync_enable_o[c] <= link_sync_q[c][POS_LINK_SYNC];
					rx_pwr_up_o[c]        <= ch_pwr_q[c][POS_RX_PWR];
					tx_pwr_up_o[c]        <= ch_pwr_q[c][POS_TX_PWR];
					// Either edge of the enable restarts synchronisation
					link_prev_q[c]   <= link_sync_q[c][POS_LINK_SYNC];
					link_nosync_o[c] <= link_prev_q[c]
						!= link_sync_q[c][POS_LINK_SYNC];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			iir_q <= RST_IIR;
		else if (iir_hit && wr_ofs == OFS_IIR_SCRATCH)
			iir_q <= wr_data;
	end

	// Read path: only single-target addresses read back; broadcast
	// addresses read zero since several copies may differ
	logic       rd_space;
	logic       rd_side;
	logic [2:0] rd_region;
	logic [3:0] rd_qsel;
	logic [7:0] rd_ofs;
	logic [2:0] rd_quad;
	logic [4:0] rd_ch;
	logic [DATA_W-1:0] rd_d;

	assign rd_space  = sb_addr_i[17:16] == ADDR_TOP;
	assign rd_side   = sb_addr_i[SIDE_BIT];
	assign rd_region = sb_addr_i[14:12];
	assign rd_qsel   = sb_addr_i[11:8];
	assign rd_ofs    = sb_addr_i[7:0];
	assign rd_quad   = {rd_side, sb_addr_i[9:8]};
	assign rd_ch     = {rd_side, sb_addr_i[11:8]};

	always_comb
	begin
		rd_d = RST_RDATA;
		if (rd_space && rd_region == REGION_QUAD && rd_qsel[3:2] == 2'b00)
		begin
			unique case (rd_ofs)
				OFS_PROTO:     rd_d = proto_q[rd_quad];
				OFS_QUAD_PWR:  rd_d = quad_pwr_q[rd_quad];
				OFS_XCVR_RST:  rd_d = xcvr_rst_q[rd_quad];
				OFS_QUAD_SRST: rd_d = quad_srst_q[rd_quad];
				default:       rd_d = RST_RDATA;
			endcase
		end
		else if (rd_space && rd_region == REGION_CH_ONE)
		begin
			unique case (rd_ofs)
				OFS_LINK_SYNC: rd_d = link_sync_q[rd_ch];
				OFS_CH_PWR:    rd_d = ch_pwr_q[rd_ch];
				default:       rd_d = RST_RDATA;
			endcase
		end
		else if (rd_space && rd_side && rd_region == REGION_QUAD
			&& rd_qsel == QSEL_IIR && rd_ofs == OFS_IIR_SCRATCH)
			rd_d = iir_q;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sb_rdata_o <= RST_RDATA;
			sb_ack_o   <= 1'b0;
		end
		else
		begin
			// Every bus request is acked, mapped or not, so a host never hangs
			sb_ack_o <= sb_we_i | sb_re_i;
			// Read data holds until the next read for a slow host
			if (sb_re_i)
				sb_rdata_o <= rd_d;
		end
	end

endmodule

// ==== tb/sqc_host.sv ====
/*
 Bus host and configuration loader model for sqc_regs.
 Assumes one clock; each request is a one-cycle strobe.
*/
`timescale 1ns/1ps

module sqc_host
	import sqc_pkg::*;
(
	// Clock
	input  wire logic              clock_i,
	// Bus and loader requests
	output logic      [ADDR_W-1:0] sb_addr_i,
	output logic      [DATA_W-1:0] sb_wdata_i,
	output logic                   sb_we_i,
	output logic                   sb_re_i,
	output logic                   cfg_we_i,
	output logic      [ADDR_W-1:0] cfg_addr_i,
	output logic      [DATA_W-1:0] cfg_data_i
);
	// Expected answers: bit 8 marks a read
	logic [8:0] exp_q[$];

	initial
	begin
		{sb_addr_i, sb_wdata_i, sb_we_i, sb_re_i} = '0;
		{cfg_we_i, cfg_addr_i, cfg_data_i} = '0;
	end

	// k: 0 read, 1 write, 2 loader write
	task automatic acc(input logic [1:0] k, input logic [17:0] a,
		input logic [7:0] v, x);
		@(posedge clock_i);
		#1;
		if (k == 2'd2)
			{cfg_we_i, cfg_addr_i, cfg_data_i} = {1'b1, a, v};
		else
		begin
			{sb_we_i, sb_re_i} = {k[0], !k[0]};
			{sb_addr_i, sb_wdata_i} = {a, v};
			exp_q.push_back({!k[0], x});
		end
		@(posedge clock_i);
		#1;
		{sb_we_i, sb_re_i, cfg_we_i} = 3'b000;
		// Idle lines flip so a stale value never looks valid
		{sb_addr_i, sb_wdata_i} = ~{sb_addr_i, sb_wdata_i};
		{cfg_addr_i, cfg_data_i} = ~{cfg_addr_i, cfg_data_i};
	endtask
endmodule

// ==== tb/sqc_regs_monitor.sv ====
/*
 Port checker for sqc_regs, bound to every instance.
 Assumes the quad 7 reset pin is never raised.
*/
`timescale 1ns/1ps

module sqc_regs_monitor
	import sqc_pkg::*;
(
	// Clock and reset
	input wire logic                 clock_i,
	input wire logic                 rst_i,
	// Requests
	input wire logic [ADDR_W-1:0]    sb_addr_i,
	input wire logic [DATA_W-1:0]    sb_wdata_i,
	input wire logic                 sb_we_i,
	input wire logic                 sb_re_i,
	input wire logic                 sb_ack_o,
	input wire logic                 cfg_we_i,
	input wire logic [ADDR_W-1:0]    cfg_addr_i,
	input wire logic [NUM_QUADS-1:0] quad_rst_i,
	// Controls
	input wire logic [NUM_QUADS-1:0] quad_pwr_up_o,
	input wire logic [NUM_QUADS-1:0] xcvr_rst_o,
	input wire logic [NUM_QUADS-1:0] xaui_mode_o,
	input wire logic [NUM_QUADS-1:0] tx_clk_sync_o,
	input wire logic [NUM_QUADS-1:0] tx_sm_xaui_o,
	input wire logic [NUM_QUADS-1:0] enc_en_o,
	input wire logic [NUM_QUADS-1:0] word_align_en_o,
	input wire logic [NUM_QUADS-1:0] dec_en_o,
	input wire logic [NUM_QUADS-1:0] rx_link_sm_xaui_o,
	input wire logic [NUM_QUADS-1:0] rx_sm_xaui_o,
	input wire logic [NUM_CH-1:0]    rx_pwr_up_o,
	input wire logic [NUM_CH-1:0]    tx_pwr_up_o,
	input wire logic [NUM_CH-1:0]    link_sync_enable_o,
	input wire logic [NUM_CH-1:0]    link_nosync_o
);
	localparam logic [17:0] A_SRST7 = BASE_QUAD_R + 18'h0_0343;
	localparam logic [17:0] A_QPWR7 = BASE_QUAD_R + 18'h0_0328;
	logic srst7_q;

	// A loader write to the soft reset is taken as set, to stay safe
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
			srst7_q <= 1'b0;
		else if (cfg_we_i && cfg_addr_i == A_SRST7)
			srst7_q <= 1'b1;
		else if (sb_we_i && sb_addr_i == A_SRST7)
			srst7_q <= sb_wdata_i[POS_QUAD_SRST];

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_ack_follows_req: assert property (
		(sb_we_i || sb_re_i) |=> sb_ack_o) else $error("ack missing");
	a_ack_only_req: assert property (
		!(sb_we_i || sb_re_i) |=> !sb_ack_o) else $error("stray ack");
	a_nosync_on_edge: assert property (
		link_nosync_o == (link_sync_enable_o ^ $past(link_sync_enable_o)))
		else $error("nosync pulse wrong");
	a_mode_copies: assert property (
		{tx_clk_sync_o, tx_sm_xaui_o, enc_en_o, word_align_en_o, dec_en_o,
		rx_link_sm_xaui_o, rx_sm_xaui_o} == {7{xaui_mode_o}})
		else $error("mode copies differ");
	a_reset_defaults: assert property ($fell(rst_i) |->
		xcvr_rst_o == '1 && quad_pwr_up_o == '0 && rx_pwr_up_o == '0
		&& tx_pwr_up_o == '0) else $error("reset values wrong");
	a_quiet_stable: assert property (
		(!sb_we_i && !cfg_we_i && quad_rst_i == '0) [*6] |->
		$stable({quad_pwr_up_o, xcvr_rst_o, xaui_mode_o, rx_pwr_up_o,
		tx_pwr_up_o, link_sync_enable_o})) else $error("output moved");
	a_pin_quad_reset: assert property (quad_rst_i[1] [*8] |->
		!quad_pwr_up_o[1] && rx_pwr_up_o[7:4] == '0)
		else $error("pin reset ignored");
	a_quad_pwr_write: assert property (
		sb_we_i && !cfg_we_i && sb_addr_i == A_QPWR7 && !srst7_q
		&& !quad_rst_i[7] |-> ##2
		quad_pwr_up_o[7] == $past(sb_wdata_i[POS_QUAD_PWR], 2))
		else $error("quad power bit wrong");

	c_read: cover property (sb_re_i ##1 sb_ack_o);
	c_nosync: cover property (link_nosync_o != '0);
	c_mode: cover property (xaui_mode_o != '0);
endmodule

bind sqc_regs sqc_regs_monitor u_mon (.*);

// ==== tb/sqc_regs_tb.sv ====
/*
 Self-checking bench for sqc_regs with a host model.
 Assumes a 50 MHz clock; reads are checked as their ack appears.
*/
`timescale 1ns/1ps

module sqc_regs_tb
	import sqc_pkg::*;
;
	logic                 clock_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic [NUM_QUADS-1:0] quad_rst_i = '0;
	logic [ADDR_W-1:0]    sb_addr_i, cfg_addr_i;
	logic [DATA_W-1:0]    sb_wdata_i, cfg_data_i, sb_rdata_o, d;
	logic                 sb_we_i, sb_re_i, cfg_we_i, sb_ack_o;
	logic [NUM_QUADS-1:0] quad_pwr_up_o, xcvr_rst_o, xaui_mode_o;
	logic [NUM_QUADS-1:0] tx_clk_sync_o, tx_sm_xaui_o, enc_en_o;
	logic [NUM_QUADS-1:0] word_align_en_o, dec_en_o, rx_link_sm_xaui_o;
	logic [NUM_QUADS-1:0] rx_sm_xaui_o, eqp, exr, exa;
	logic [NUM_CH-1:0]    rx_pwr_up_o, tx_pwr_up_o, link_sync_enable_o;
	logic [NUM_CH-1:0]    link_nosync_o, erx, etx, els;
	logic [8:0]           e;
	int                   num_errors = 0;
	int                   cmp_count = 0;

	sqc_regs u_dut (.*);
	sqc_host u_host (.*);

	always #10 clock_i = ~clock_i;

	task automatic chk(input logic [63:0] g, x);
		cmp_count++;
		if (g !== x)
		begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic chk_rd(input logic [7:0] g, x);
		chk(g, x);
	endtask
	task automatic w(input logic [17:0] a, input logic [7:0] v);
		u_host.acc(2'd1, a, v, 8'h00);
	endtask
	task automatic r(input logic [17:0] a, input logic [7:0] x);
		u_host.acc(2'd0, a, 8'h00, x);
	endtask
	task automatic l(input logic [17:0] a, input logic [7:0] v);
		u_host.acc(2'd2, a, v, 8'h00);
	endtask
	task automatic fin(input string n);
		repeat (3) @(posedge clock_i);
		#2;
		chk(quad_pwr_up_o, eqp);
		chk(xcvr_rst_o, exr);
		chk(xaui_mode_o, exa);
		chk({tx_clk_sync_o, tx_sm_xaui_o, enc_en_o}, {3{exa}});
		chk({word_align_en_o, dec_en_o, rx_link_sm_xaui_o, rx_sm_xaui_o},
			{4{exa}});
		chk(rx_pwr_up_o, erx);
		chk(tx_pwr_up_o, etx);
		chk(link_sync_enable_o, els);
		chk(link_nosync_o, '0);
		$display("test %s done", n);
	endtask
	task automatic wrap_up;
		// An unanswered request counts against the run
		if (u_host.exp_q.size() != 0)
			num_errors++;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clock_i)
		if (sb_ack_o === 1'b1 && u_host.exp_q.size() > 0)
		begin
			e = u_host.exp_q.pop_front();
			if (e[8])
				chk_rd(sb_rdata_o, e[7:0]);
		end

	initial
	begin
		#100000;
		num_errors++;
		wrap_up;
	end

	initial
	begin
		d = 8'($urandom(89924));
		{eqp, exa, erx, etx, els} = '0;
		exr = '1;
		repeat (4) @(posedge clock_i);
		#1 rst_i = 1'b0;
		r(18'h3_6041, RST_XCVR_RST);
		r(18'h3_5013, RST_CH_PWR);
		fin("defaults");
		w(18'h3_5913, 8'h03);
		{erx[9], etx[9]} = 2'b11;
		r(18'h3_5913, 8'h03);
		r(18'h3_5813, 8'h00);
		fin("single channel");
		w(18'h3_1013, 8'h02);
		erx[7:4] = '1;
		r(18'h3_5513, 8'h02);
		r(18'h3_1013, 8'h00);
		fin("four channel broadcast");
		w(18'h3_C000, 8'h01);
		els[31:16] = '1;
		// The restart pulse stands for one cycle, with the enable output
		@(posedge clock_i);
		#2 chk(link_nosync_o, 32'hFFFF_0000);
		r(18'h3_D700, 8'h01);
		fin("side broadcast");
		w(18'h3_C000, 8'h00);
		els = '0;
		@(posedge clock_i);
		#2 chk(link_nosync_o, 32'hFFFF_0000);
		fin("link off");
		// Fully bonded package assumed for the broadcast power-up
		w(18'h3_6428, 8'h40);
		eqp[3:0] = '1;
		r(18'h3_6328, 8'h40);
		r(18'h3_E028, 8'h00);
		d = 8'($urandom);
		w(18'h3_E328, d);
		eqp[7] = d[POS_QUAD_PWR];
		fin("quad power");
		w(18'h3_E118, PROTO_XAUI);
		w(18'h3_6018, 8'h03);
		exa[5] = 1'b1;
		w(18'h3_E041, 8'h00);
		exr[4] = 1'b0;
		w(18'h3_E441, 8'h00);
		exr[7:4] = '0;
		r(18'h3_E141, 8'h00);
		fin("mode and release");
		d = 8'($urandom);
		w(BASE_IIR, d);
		r(BASE_IIR, d);
		l(18'h3_6328, 8'h00);
		l(18'h3_D813, 8'h01);
		eqp[3] = 1'b0;
		etx[24] = 1'b1;
		fin("shared and loader");
		w(18'h3_E043, 8'h01);
		exr[4] = 1'b1;
		r(18'h3_E041, RST_XCVR_RST);
		fin("soft reset");
		w(18'h3_E043, 8'h00);
		w(18'h3_E041, 8'h00);
		exr[4] = 1'b0;
		@(posedge clock_i);
		#1 quad_rst_i[1] = 1'b1;
		repeat (8) @(posedge clock_i);
		#1 quad_rst_i[1] = 1'b0;
		eqp[1] = 1'b0;
		erx[7:4] = '0;
		repeat (6) @(posedge clock_i);
		fin("pin reset");
		wrap_up;
	end
endmodule
